// >>> stmon_pkg.sv
// stmon_pkg: constants, object map and carrier types of the sync timing monitor
// assumes one 25 MHz clock; the object dictionary is reached by index and sub-index
package stmon_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned     CLK_PERIOD_NS  = 40;
  localparam logic [31:0]     NS_PER_CLK     = 32'(CLK_PERIOD_NS);
  localparam logic [31:0]     MIN_CYCLE_NS   = 32'h0003D090;
  localparam int unsigned     MIN_SHIFT_NS   = 1000;

  // ----------------------------------------------------------------------
  // object indices and sub-indices
  // ----------------------------------------------------------------------
  localparam logic [15:0] IDX_OUT_PARAM    = 16'h1C32;
  localparam logic [15:0] IDX_IN_PARAM     = 16'h1C33;
  localparam logic [7:0]  SUB_COUNT        = 8'h00;
  localparam logic [7:0]  SUB_SYNC_MODE    = 8'h01;
  localparam logic [7:0]  SUB_CYCLE_TIME   = 8'h02;
  localparam logic [7:0]  SUB_SHIFT_TIME   = 8'h03;
  localparam logic [7:0]  SUB_SUPPORTED    = 8'h04;
  localparam logic [7:0]  SUB_MIN_CYCLE    = 8'h05;
  localparam logic [7:0]  SUB_CALC_COPY    = 8'h06;
  localparam logic [7:0]  SUB_MIN_DELAY    = 8'h07;
  localparam logic [7:0]  SUB_COMMAND      = 8'h08;
  localparam logic [7:0]  SUB_MAX_DELAY    = 8'h09;
  localparam logic [7:0]  SUB_MISSED       = 8'h0B;
  localparam logic [7:0]  SUB_OVERRUN      = 8'h0C;
  localparam logic [7:0]  SUB_SHORT_SHIFT  = 8'h0D;
  localparam logic [7:0]  SUB_FRAME_REPEAT = 8'h14;
  localparam logic [7:0]  SUB_SYNC_ERROR   = 8'h20;

  // ----------------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RST_IN_PARAM_COUNT = 8'h20;
  localparam logic [15:0] RST_SYNC_MODE      = 16'h0022;
  localparam logic [31:0] RST_CYCLE_TIME     = 32'h000F4240;
  localparam logic [31:0] RST_MIN_CYCLE      = 32'h0003D090;
  localparam logic [15:0] RST_SUPPORTED      = 16'h0C07;
  localparam logic [15:0] CMD_STOP           = 16'h0000;
  localparam logic [15:0] CMD_START          = 16'h0001;

  localparam logic [15:0] MODE_FREE_RUN      = 16'h0000;
  localparam logic [15:0] MODE_IN_BUFFER     = 16'h0001;
  localparam logic [15:0] MODE_FIRST_SYNC    = 16'h0002;
  localparam logic [15:0] MODE_SECOND_SYNC   = 16'h0003;
  localparam logic [15:0] MODE_OUT_BUFFER    = 16'h0022;

  localparam int          SUP_SHIFT_LSB      = 4;
  localparam int          SUP_DYNAMIC_BIT    = 14;
  localparam logic [1:0]  SHIFT_LOCAL_EVENT  = 2'h1;
  localparam logic [1:0]  SHIFT_SECOND_SYNC  = 2'h2;

  // ----------------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        req;
    logic        write;
    logic [15:0] index;
    logic [7:0]  subindex;
    logic [31:0] wdata;
  } stmon_req_type;

  typedef struct packed {
    logic        ack;
    logic        abort;
    logic [31:0] rdata;
  } stmon_rsp_type;

  typedef struct packed {
    logic first_sync_pulse;
    logic second_sync_pulse;
    logic output_buffer_manager;
    logic outputs_driven;
    logic inputs_sampled;
    logic inputs_available;
  } stmon_evt_type;

  typedef struct packed {
    logic [15:0]   out_cmd;
    logic [15:0]   in_cmd;
    logic          meas;
    logic [31:0]   out_max_delay;
    logic [31:0]   out_frame_repeat;
    logic [31:0]   in_frame_repeat;
    logic          sync_err;
    logic [15:0]   sync_mode;
    logic [31:0]   cycle_time;
    logic [31:0]   shift_time;
    logic [31:0]   min_cycle;
    logic [31:0]   calc_copy;
    logic [31:0]   min_delay;
    logic [31:0]   in_max_delay;
    logic [31:0]   now;
    logic [31:0]   t_first;
    logic [31:0]   t_second;
    logic [31:0]   t_sampled;
    logic          first_seen;
    logic          out_pending;
    logic          buf_seen;
    stmon_rsp_type rsp;
  } stmon_state_type;

endpackage : stmon_pkg

// >>> stmon_satcnt.sv
// stmon_satcnt: saturating event counter
// assumes a synchronous active-high reset and a one-cycle increment pulse
`timescale 1ns/100ps
`default_nettype none

module stmon_satcnt #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             inc,
  output var  logic [WIDTH-1:0] count
);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  if (WIDTH < 1) begin : g_chk
    $error("stmon_satcnt: WIDTH must be at least 1");
  end

  always_comb begin
    count_nxt = count_r;
    // holding at all-ones keeps a busy link from reading as nearly idle
    if (inc && (count_r != {WIDTH{1'b1}})) begin
      count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;

endmodule : stmon_satcnt

`default_nettype wire

// >>> stmon_top.sv
// stmon_top: sync parameter objects and timing diagnostics of a fieldbus slave terminal
// assumes all inputs synchronous to MCLK; timing events are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none

module stmon_top
  import stmon_pkg::*;
#(
  parameter int unsigned SHORT_SHIFT_NS = stmon_pkg::MIN_SHIFT_NS,
  parameter bit          DYNAMIC_TIMES  = 1'b1,
  parameter int          COUNT_WIDTH    = 16
) (
  input  wire logic                    MCLK,
  input  wire logic                    RST,
  input  wire stmon_pkg::stmon_req_type OBJ_REQ,
  output var  stmon_pkg::stmon_rsp_type OBJ_RSP,
  input  wire stmon_pkg::stmon_evt_type EVT,
  input  wire logic                    DISTRIBUTED_CLOCK_MODE,
  input  wire logic                    RUN_STATE
);
  import stmon_pkg::*;

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (COUNT_WIDTH != 16) begin : g_chk_cnt
    $error("stmon_top: diagnostic counters are 16 bit objects");
  end
  if (SHORT_SHIFT_NS == 0) begin : g_chk_shift
    $error("stmon_top: SHORT_SHIFT_NS must be nonzero");
  end

  localparam logic [31:0] SHORT_SHIFT = 32'(SHORT_SHIFT_NS);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] elapsed(input logic [31:0] t_now, input logic [31:0] t_then);
    elapsed = t_now - t_then;
  endfunction : elapsed

  function automatic logic [31:0] keep_max(input logic [31:0] cur, input logic [31:0] cand);
    keep_max = (cand > cur) ? cand : cur;
  endfunction : keep_max

  function automatic logic legal_mode(input logic [15:0] m);
    legal_mode = (m == MODE_FREE_RUN) || (m == MODE_IN_BUFFER) || (m == MODE_FIRST_SYNC) ||
                 (m == MODE_SECOND_SYNC) || (m == MODE_OUT_BUFFER);
  endfunction : legal_mode

  stmon_state_type s_r;
  stmon_state_type s_nxt;

  logic                   late_evt;
  logic                   early_evt;
  logic                   missed_evt;
  logic                   short_evt;
  logic [COUNT_WIDTH-1:0] missed_cnt;
  logic [COUNT_WIDTH-1:0] overrun_cnt;
  logic [COUNT_WIDTH-1:0] short_cnt;
  logic [15:0]            supported;

  // ----------------------------------------------------------------------
  // cycle event detection
  // ----------------------------------------------------------------------
  // a first sync pulse while outputs of the previous cycle are still pending means they came too late
  assign late_evt   = EVT.first_sync_pulse && s_r.out_pending;
  assign early_evt  = EVT.first_sync_pulse && s_r.first_seen &&
                      (elapsed(s_r.now, s_r.t_first) < MIN_CYCLE_NS);
  assign missed_evt = DISTRIBUTED_CLOCK_MODE && RUN_STATE && EVT.first_sync_pulse &&
                      s_r.first_seen && !s_r.buf_seen;
  assign short_evt  = DISTRIBUTED_CLOCK_MODE && EVT.second_sync_pulse && s_r.first_seen &&
                      (elapsed(s_r.now, s_r.t_first) < SHORT_SHIFT);

  stmon_satcnt #(.WIDTH(COUNT_WIDTH)) u_missed (
    .clk   (MCLK),
    .rst   (RST),
    .inc   (missed_evt),
    .count (missed_cnt)
  );

  stmon_satcnt #(.WIDTH(COUNT_WIDTH)) u_overrun (
    .clk   (MCLK),
    .rst   (RST),
    .inc   (RUN_STATE && (late_evt || early_evt)),
    .count (overrun_cnt)
  );

  stmon_satcnt #(.WIDTH(COUNT_WIDTH)) u_short (
    .clk   (MCLK),
    .rst   (RST),
    .inc   (short_evt),
    .count (short_cnt)
  );

  // ----------------------------------------------------------------------
  // supported modes
  // ----------------------------------------------------------------------
  always_comb begin
    supported = RST_SUPPORTED;
    if (s_r.sync_mode == MODE_OUT_BUFFER) begin
      supported[SUP_SHIFT_LSB +: 2] = SHIFT_LOCAL_EVENT;
    end else if (s_r.sync_mode == MODE_SECOND_SYNC) begin
      supported[SUP_SHIFT_LSB +: 2] = SHIFT_SECOND_SYNC;
    end
    supported[SUP_DYNAMIC_BIT] = DYNAMIC_TIMES;
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic        is_out;
    logic        is_in;
    logic        hit;
    logic        wr;
    logic [31:0] rd;
    logic        dc_meas;
    is_out  = OBJ_REQ.index == IDX_OUT_PARAM;
    is_in   = OBJ_REQ.index == IDX_IN_PARAM;
    hit     = 1'b0;
    wr      = OBJ_REQ.req && OBJ_REQ.write;
    rd      = 32'h00000000;
    dc_meas = s_r.meas && DISTRIBUTED_CLOCK_MODE;
    s_nxt   = s_r;

    s_nxt.now = s_r.now + NS_PER_CLK;
    s_nxt.rsp = '0;

    // time stamps and cycle bookkeeping
    if (EVT.first_sync_pulse) begin
      s_nxt.t_first    = s_r.now;
      s_nxt.first_seen = 1'b1;
      s_nxt.buf_seen   = 1'b0;
      s_nxt.out_pending = 1'b0;
      if (DISTRIBUTED_CLOCK_MODE) begin
        s_nxt.sync_err = late_evt;
      end
      if (s_r.meas && s_r.first_seen) begin
        s_nxt.min_cycle = keep_max(s_r.min_cycle, elapsed(s_r.now, s_r.t_first));
      end
    end
    // an event in the same cycle as the clear still counts for the cycle that starts
    if (EVT.output_buffer_manager) begin
      s_nxt.buf_seen = 1'b1;
    end
    if (EVT.second_sync_pulse) begin
      s_nxt.t_second    = s_r.now;
      s_nxt.out_pending = 1'b1;
    end
    if (EVT.outputs_driven) begin
      s_nxt.out_pending = 1'b0;
      if (dc_meas) begin
        s_nxt.out_max_delay = keep_max(s_r.out_max_delay, elapsed(s_r.now, s_r.t_second));
      end
    end
    if (EVT.inputs_sampled) begin
      s_nxt.t_sampled = s_r.now;
      if (dc_meas) begin
        s_nxt.shift_time   = keep_max(s_r.shift_time, elapsed(s_r.now, s_r.t_first));
        s_nxt.in_max_delay = keep_max(s_r.in_max_delay, elapsed(s_r.now, s_r.t_second));
      end
    end
    if (EVT.inputs_available && dc_meas) begin
      s_nxt.calc_copy = keep_max(s_r.calc_copy, elapsed(s_r.now, s_r.t_sampled));
      s_nxt.min_delay = keep_max(s_r.min_delay, elapsed(s_r.now, s_r.t_second));
    end
    if (!DISTRIBUTED_CLOCK_MODE) begin
      s_nxt.sync_err = 1'b0;
    end

    // object access
    if (is_out) begin
      hit = 1'b1;
      case (OBJ_REQ.subindex)
        SUB_COMMAND:      rd = {16'h0000, s_r.out_cmd};
        SUB_MAX_DELAY:    rd = s_r.out_max_delay;
        SUB_MISSED:       rd = {16'h0000, missed_cnt};
        SUB_OVERRUN:      rd = {16'h0000, overrun_cnt};
        SUB_SHORT_SHIFT:  rd = {16'h0000, short_cnt};
        SUB_FRAME_REPEAT: rd = s_r.out_frame_repeat;
        SUB_SYNC_ERROR:   rd = {31'h00000000, s_r.sync_err};
        default:          hit = 1'b0;
      endcase
    end else if (is_in) begin
      hit = 1'b1;
      case (OBJ_REQ.subindex)
        SUB_COUNT:        rd = {24'h000000, RST_IN_PARAM_COUNT};
        SUB_SYNC_MODE:    rd = {16'h0000, s_r.sync_mode};
        SUB_CYCLE_TIME:   rd = s_r.cycle_time;
        SUB_SHIFT_TIME:   rd = s_r.shift_time;
        SUB_SUPPORTED:    rd = {16'h0000, supported};
        SUB_MIN_CYCLE:    rd = s_r.min_cycle;
        SUB_CALC_COPY:    rd = s_r.calc_copy;
        SUB_MIN_DELAY:    rd = s_r.min_delay;
        SUB_COMMAND:      rd = {16'h0000, s_r.in_cmd};
        SUB_MAX_DELAY:    rd = s_r.in_max_delay;
        SUB_MISSED:       rd = {16'h0000, missed_cnt};
        SUB_OVERRUN:      rd = {16'h0000, overrun_cnt};
        SUB_SHORT_SHIFT:  rd = {16'h0000, short_cnt};
        SUB_FRAME_REPEAT: rd = s_r.in_frame_repeat;
        SUB_SYNC_ERROR:   rd = {31'h00000000, s_r.sync_err};
        default:          hit = 1'b0;
      endcase
    end

    if (OBJ_REQ.req) begin
      s_nxt.rsp.ack   = 1'b1;
      s_nxt.rsp.abort = !hit;
      if (!OBJ_REQ.write && hit) begin
        s_nxt.rsp.rdata = rd;
      end
    end

    if (wr && hit) begin
      if (OBJ_REQ.subindex == SUB_COMMAND) begin
        if (is_out) begin
          s_nxt.out_cmd = OBJ_REQ.wdata[15:0];
        end else begin
          s_nxt.in_cmd = OBJ_REQ.wdata[15:0];
        end
        if (OBJ_REQ.wdata[15:0] == CMD_START) begin
          s_nxt.meas = 1'b1;
          if (!s_r.meas) begin
            // stale maxima would hide a better timing after reconfiguration
            s_nxt.out_max_delay = '0;
            s_nxt.shift_time    = '0;
            s_nxt.min_cycle     = '0;
            s_nxt.calc_copy     = '0;
            s_nxt.min_delay     = '0;
            s_nxt.in_max_delay  = '0;
          end
        end else if (OBJ_REQ.wdata[15:0] == CMD_STOP) begin
          s_nxt.meas = 1'b0;
        end
      end else if (OBJ_REQ.subindex == SUB_FRAME_REPEAT) begin
        if (is_out) begin
          s_nxt.out_frame_repeat = OBJ_REQ.wdata;
        end else begin
          s_nxt.in_frame_repeat = OBJ_REQ.wdata;
        end
      end else if (is_in && (OBJ_REQ.subindex == SUB_SYNC_MODE) && legal_mode(OBJ_REQ.wdata[15:0])) begin
        s_nxt.sync_mode = OBJ_REQ.wdata[15:0];
      end else if (is_in && (OBJ_REQ.subindex == SUB_CYCLE_TIME)) begin
        s_nxt.cycle_time = OBJ_REQ.wdata;
      end else begin
        // read-only entry or illegal mode code
        s_nxt.rsp.abort = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      s_r            <= '0;
      s_r.sync_mode  <= RST_SYNC_MODE;
      s_r.cycle_time <= RST_CYCLE_TIME;
      s_r.min_cycle  <= RST_MIN_CYCLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign OBJ_RSP = s_r.rsp;

endmodule : stmon_top

`default_nettype wire

// >>> stmon_unused_guard.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// >>> stmon_top_sva.sv
// stmon_top_sva: object port decode and response assertions for stmon_top
// assumes it is bound to stmon_top and sees only that module's ports
`timescale 1ns/100ps
`default_nettype none

module stmon_top_chk
  import stmon_pkg::*;
(
  input wire logic                     MCLK,
  input wire logic                     RST,
  input wire stmon_pkg::stmon_req_type OBJ_REQ,
  input wire stmon_pkg::stmon_rsp_type OBJ_RSP,
  input wire logic                     DISTRIBUTED_CLOCK_MODE
);
  import stmon_pkg::*;

  // ----------------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  wire logic        rd  = OBJ_REQ.req && !OBJ_REQ.write;
  wire logic        wr  = OBJ_REQ.req && OBJ_REQ.write;
  wire logic [23:0] key = {OBJ_REQ.index, OBJ_REQ.subindex};
  // the sync mode object is 16 bit wide, only the low half of the write word is decoded
  wire logic        mode_ok = OBJ_REQ.wdata[15:0] inside {16'h0, 16'h1, 16'h2, 16'h3, 16'h22};
  wire logic        is_cmd = key == {IDX_OUT_PARAM, SUB_COMMAND} || key == {IDX_IN_PARAM, SUB_COMMAND};

  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  property p_cmd_write;
    wr && is_cmd |=> OBJ_RSP.ack && !OBJ_RSP.abort;
  endproperty
  a_cmd_write: assert property (p_cmd_write) else $error("command write refused");
  property p_count_read;
    rd && key == {IDX_IN_PARAM, SUB_COUNT} |=> OBJ_RSP.ack && !OBJ_RSP.abort && OBJ_RSP.rdata == 32'h20;
  endproperty
  a_count_read: assert property (p_count_read) else $error("sub-entry count wrong");
  property p_count_ro;
    wr && key == {IDX_IN_PARAM, SUB_COUNT} |=> OBJ_RSP.ack && OBJ_RSP.abort;
  endproperty
  a_count_ro: assert property (p_count_ro) else $error("sub-entry count written");
  property p_mode_good;
    wr && key == {IDX_IN_PARAM, SUB_SYNC_MODE} && mode_ok |=> OBJ_RSP.ack && !OBJ_RSP.abort;
  endproperty
  a_mode_good: assert property (p_mode_good) else $error("valid sync mode refused");
  property p_mode_bad;
    wr && key == {IDX_IN_PARAM, SUB_SYNC_MODE} && !mode_ok |=> OBJ_RSP.ack && OBJ_RSP.abort;
  endproperty
  a_mode_bad: assert property (p_mode_bad) else $error("invalid sync mode taken");
  property p_sup_read;
    rd && key == {IDX_IN_PARAM, SUB_SUPPORTED} |=> OBJ_RSP.rdata[3:0] == 4'h7 && OBJ_RSP.rdata[14];
  endproperty
  a_sup_read: assert property (p_sup_read) else $error("supported modes wrong");
  property p_max_ro;
    wr && key == {IDX_OUT_PARAM, SUB_MAX_DELAY} |=> OBJ_RSP.ack && OBJ_RSP.abort;
  endproperty
  a_max_ro: assert property (p_max_ro) else $error("max delay written");
  property p_err_ro;
    wr && key == {IDX_OUT_PARAM, SUB_SYNC_ERROR} |=> OBJ_RSP.abort;
  endproperty
  a_err_ro: assert property (p_err_ro) else $error("sync error written");
  property p_err_nodc;
    (!DISTRIBUTED_CLOCK_MODE)[*3] ##0 (rd && key == {IDX_OUT_PARAM, SUB_SYNC_ERROR}) |=> OBJ_RSP.rdata == 32'h0;
  endproperty
  a_err_nodc: assert property (p_err_nodc) else $error("sync error set outside dc mode");

  c_start: cover property (wr && is_cmd && OBJ_REQ.wdata == 32'h1);
  c_mode_bad: cover property (wr && key == {IDX_IN_PARAM, SUB_SYNC_MODE} && !mode_ok);
  c_err_nodc: cover property (!DISTRIBUTED_CLOCK_MODE && rd && key == {IDX_OUT_PARAM, SUB_SYNC_ERROR});
endmodule : stmon_top_chk

bind stmon_top stmon_top_chk stmon_top_chk_inst (.MCLK(MCLK), .RST(RST), .OBJ_REQ(OBJ_REQ), .OBJ_RSP(OBJ_RSP),
  .DISTRIBUTED_CLOCK_MODE(DISTRIBUTED_CLOCK_MODE));
`default_nettype wire

// >>> stmon_sync_master.sv
// stmon_sync_master: sync pulse and buffer event source standing in for the bus master side
// assumes it changes on the falling edge of MCLK; every event is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none

module stmon_sync_master
  import stmon_pkg::*;
(
  input  wire logic                     MCLK,
  input  wire logic                     go,
  input  wire logic                     miss,
  input  wire logic [7:0]               period,
  input  wire logic [7:0]               shift,
  input  wire logic [7:0]               odly,
  output var  stmon_pkg::stmon_evt_type evt
);
  logic [7:0] cnt_r;

  initial begin
    evt = '0;
    cnt_r = 8'h00;
  end

  // a delay past the period never drives outputs, which models a late cycle
  always @(negedge MCLK) begin
    evt <= '0;
    if (go) begin
      cnt_r <= (cnt_r == period - 8'h01) ? 8'h00 : cnt_r + 8'h01;
      evt.first_sync_pulse <= cnt_r == 8'h00;
      evt.output_buffer_manager <= cnt_r == 8'h01 && !miss;
      evt.second_sync_pulse <= cnt_r == shift;
      evt.outputs_driven <= cnt_r == shift + odly;
      evt.inputs_sampled <= cnt_r == shift + odly;
      evt.inputs_available <= cnt_r == shift + odly + 8'h02;
    end
  end
endmodule : stmon_sync_master
`default_nettype wire

// >>> stmon_top_test.sv
// stmon_top_test: directed test of the object port and timing diagnostics of stmon_top
// assumes the package, design, checker and stmon_sync_master are compiled before it
`timescale 1ns/100ps
`default_nettype none

module stmon_top_test;
  import stmon_pkg::*;
  logic          mclk;
  logic          rst;
  stmon_req_type req;
  stmon_rsp_type rsp;
  stmon_evt_type evt;
  logic          dc;
  logic          run;
  logic          go;
  logic          miss;
  logic [7:0]    odly;
  logic [31:0]   got;
  int            n_fail;
  int            n_checks;
  logic [7:0]    rsub [5] = '{SUB_COUNT, SUB_SYNC_MODE, SUB_CYCLE_TIME, SUB_MIN_CYCLE, SUB_SUPPORTED};
  logic [31:0]   rexp [5] = '{32'h20, 32'h22, 32'h000F4240, 32'h0003D090, 32'h4C17};
  logic [15:0]   modes [5] = '{MODE_FREE_RUN, MODE_IN_BUFFER, MODE_FIRST_SYNC, MODE_SECOND_SYNC, MODE_OUT_BUFFER};
  logic [1:0]    shsel [5] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h1};

  stmon_top stmon_top_inst (.MCLK(mclk), .RST(rst), .OBJ_REQ(req), .OBJ_RSP(rsp), .EVT(evt),
    .DISTRIBUTED_CLOCK_MODE(dc), .RUN_STATE(run));
  // ten-cycle sync period, second pulse two cycles after the first
  stmon_sync_master stmon_sync_master_inst (.MCLK(mclk), .go(go), .miss(miss), .period(8'h0A),
    .shift(8'h02), .odly(odly), .evt(evt));

  // ----------------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
                        input logic ab);
    @(negedge mclk);
    req = '{req: 1'b1, write: w, index: idx, subindex: sub, wdata: wd};
    @(negedge mclk);
    req = '0;
    // the answer stands for the one cycle after the taking edge, so it is read at this falling edge
    chk($sformatf("ack abort %h:%h", idx, sub), {30'h0, 1'b1, ab}, {30'h0, rsp.ack, rsp.abort});
    got = rsp.rdata;
  endtask : access

  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
    access(1'b0, idx, sub, 32'h0, 1'b0);
    chk($sformatf("rdata %h:%h", idx, sub), exp, got);
  endtask : rd

  task automatic rd_nz(input logic [15:0] idx, input logic [7:0] sub);
    access(1'b0, idx, sub, 32'h0, 1'b0);
    chk($sformatf("nonzero %h:%h", idx, sub), 32'h1, {31'h0, got != 32'h0});
  endtask : rd_nz

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // the sequence needs well under a thousand cycles
  initial begin
    #(40 * 4000);
    n_fail++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    req = '0;
    dc = 1'b1;
    run = 1'b1;
    go = 1'b0;
    miss = 1'b0;
    odly = 8'h03;
    n_fail = 0;
    n_checks = 0;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    for (int i = 0; i < 5; i++) rd(IDX_IN_PARAM, rsub[i], rexp[i]);
    for (int i = 0; i < 5; i++) begin
      access(1'b1, IDX_IN_PARAM, SUB_SYNC_MODE, {16'h0, modes[i]}, 1'b0);
      rd(IDX_IN_PARAM, SUB_SYNC_MODE, {16'h0, modes[i]});
      rd(IDX_IN_PARAM, SUB_SUPPORTED, 32'h4C07 | {26'h0, shsel[i], 4'h0});
    end
    access(1'b1, IDX_IN_PARAM, SUB_SYNC_MODE, 32'h4, 1'b1);
    rd(IDX_IN_PARAM, SUB_SYNC_MODE, 32'h22);
    access(1'b1, IDX_IN_PARAM, SUB_CYCLE_TIME, 32'h0007A120, 1'b0);
    rd(IDX_IN_PARAM, SUB_CYCLE_TIME, 32'h0007A120);
    access(1'b1, IDX_IN_PARAM, SUB_COUNT, 32'h1, 1'b1);
    access(1'b0, IDX_IN_PARAM, 8'h0A, 32'h0, 1'b1);
    access(1'b1, IDX_OUT_PARAM, SUB_MAX_DELAY, 32'h1, 1'b1);
    run = 1'b0;
    go = 1'b1;
    repeat (30) @(negedge mclk);
    rd(IDX_OUT_PARAM, SUB_OVERRUN, 32'h0);
    run = 1'b1;
    rd(IDX_OUT_PARAM, SUB_MISSED, 32'h0);
    access(1'b1, IDX_OUT_PARAM, SUB_COMMAND, 32'h1, 1'b0);
    repeat (40) @(negedge mclk);
    access(1'b1, IDX_OUT_PARAM, SUB_COMMAND, 32'h0, 1'b0);
    rd(IDX_OUT_PARAM, SUB_COMMAND, 32'h0);
    rd(IDX_OUT_PARAM, SUB_MAX_DELAY, 32'd120);
    rd(IDX_IN_PARAM, SUB_MAX_DELAY, 32'd120);
    rd(IDX_IN_PARAM, SUB_SHIFT_TIME, 32'd200);
    rd(IDX_IN_PARAM, SUB_CALC_COPY, 32'd80);
    rd(IDX_IN_PARAM, SUB_MIN_DELAY, 32'd200);
    rd(IDX_IN_PARAM, SUB_MIN_CYCLE, 32'd400);
    rd_nz(IDX_OUT_PARAM, SUB_OVERRUN);
    rd_nz(IDX_OUT_PARAM, SUB_SHORT_SHIFT);
    odly = 8'h01;
    repeat (30) @(negedge mclk);
    access(1'b1, IDX_IN_PARAM, SUB_COMMAND, 32'h1, 1'b0);
    repeat (40) @(negedge mclk);
    access(1'b1, IDX_IN_PARAM, SUB_COMMAND, 32'h0, 1'b0);
    rd(IDX_OUT_PARAM, SUB_MAX_DELAY, 32'd40);
    rd(IDX_IN_PARAM, SUB_SHIFT_TIME, 32'd120);
    miss = 1'b1;
    repeat (30) @(negedge mclk);
    rd_nz(IDX_OUT_PARAM, SUB_MISSED);
    odly = 8'h0C;
    repeat (30) @(negedge mclk);
    rd(IDX_OUT_PARAM, SUB_SYNC_ERROR, 32'h1);
    access(1'b1, IDX_OUT_PARAM, SUB_SYNC_ERROR, 32'h0, 1'b1);
    dc = 1'b0;
    repeat (3) @(negedge mclk);
    rd(IDX_OUT_PARAM, SUB_SYNC_ERROR, 32'h0);
    complete_run();
  end
endmodule : stmon_top_test
`default_nettype wire
